/* File: bench/hsc_host_model.sv */
`default_nettype none
module hsc_host_model (
    // Clock
    input wire logic                  sys_clk,
    // Request toward the register bank
    output var hsc_pkg::hsc_bus_req_t bus_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial bus_req = '0;
    // One request held across one rising edge
    task automatic xfer(input hsc_pkg::hsc_bus_req_t r);
        bus_req = r;
        @(negedge sys_clk);
        bus_req = '0;
    endtask : xfer
endmodule : hsc_host_model
`default_nettype wire

/* File: bench/hsc_regs_properties.sv */
`default_nettype none
module hsc_regs_properties (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // Watched ports
    input wire hsc_pkg::hsc_bus_req_t bus_req,
    input wire logic [5:0]            fault_evt,
    input wire logic [7:0]            status_raw,
    input wire logic                  gpio_i,
    input wire logic [7:0]            rd_data,
    input wire logic                  mass_write_en,
    input wire logic                  adc_halt,
    input wire logic                  switch_on,
    input wire logic                  oc_retry,
    input wire logic                  gpio_oe,
    input wire logic                  alert_n_o,
    input wire logic                  alert_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic ctl_wr;
    assign ctl_wr = bus_req.wr_en && bus_req.ptr_load
                    && bus_req.ptr_val[2:0] == 3'h0;
    ////////////////////////////////////////////////////////////////////////
    a_ctl_test: assert property (ctl_wr |=> adc_halt == $past(bus_req.wr_data[5]))
        else $error("test mode bit not applied");
    a_mass_write: assert property (ctl_wr |=> mass_write_en == $past(bus_req.wr_data[4]))
        else $error("mass write bit not applied");
    a_switch_ctl: assert property (ctl_wr |=> switch_on == $past(bus_req.wr_data[3]))
        else $error("switch bit not applied");
    a_oc_retry: assert property (ctl_wr |=> oc_retry == $past(bus_req.wr_data[2]))
        else $error("overcurrent retry bit not applied");
    a_gpio_input: assert property (ctl_wr && bus_req.wr_data[7:6] == 2'b11 |=> ##1 !gpio_oe)
        else $error("gpio driven in input mode");
    a_stat_read: assert property (bus_req.ptr_load && !bus_req.wr_en
        && bus_req.ptr_val[2:0] == 3'h2 ##1 !bus_req.ptr_load
        |=> rd_data == {status_raw[7], gpio_i, status_raw[5:0]})
        else $error("status read wrong");
    a_alert_low: assert property (alert_n_o == 1'b0)
        else $error("alert drive level not low");
    a_alert_clear: assert property ((bus_req.addressed || bus_req.ara_won)
        && fault_evt == 6'h00 |=> !alert_oe)
        else $error("alert kept after release");
    a_alert_cause: assert property ($rose(alert_oe)
        |-> $past(fault_evt) != 6'h00 || $past(fault_evt, 2) != 6'h00)
        else $error("alert without fault event");
endmodule : hsc_regs_properties
`default_nettype wire

/* File: bench/tb_hsc_regs.sv */
`default_nettype none
module tb_hsc_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    wire hsc_pkg::hsc_bus_req_t bus_req;
    hsc_pkg::hsc_adc_res_t adc_res = '0;
    logic [5:0]            fault_evt = '0;
    logic [7:0]            status_raw = 8'h00;
    logic                  on_pin = 1'b0;
    logic                  debounce_done = 1'b0;
    logic                  gpio_i = 1'b0;
    logic [7:0]            rd_data;
    logic                  mass_write_en, adc_halt, switch_on, oc_retry;
    logic                  uv_retry, ov_retry, gpio_o, gpio_oe;
    logic                  alert_n_o, alert_oe;
    logic [7:0]            mdl [8] = '{8'h13, 0, 0, 0, 0, 0, 0, 0};
    logic [7:0]            d, en;
    logic [2:0]            p;
    int                    err_total = 0;
    int                    comparisons = 0;
    int                    cyc = 0;
    always #50 sys_clk = ~sys_clk;
    hsc_host_model u_host (.sys_clk(sys_clk), .bus_req(bus_req));
    hsc_regs u_hsc_regs (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
        .rd_data(rd_data), .mass_write_en(mass_write_en), .adc_res(adc_res),
        .adc_halt(adc_halt), .fault_evt(fault_evt), .status_raw(status_raw),
        .on_pin(on_pin), .debounce_done(debounce_done), .switch_on(switch_on),
        .oc_retry(oc_retry), .uv_retry(uv_retry), .ov_retry(ov_retry),
        .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
        .alert_n_o(alert_n_o), .alert_oe(alert_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] exp_rd(input logic [2:0] a);
        if (a == hsc_pkg::OFS_STATUS) begin
            return {status_raw[7], gpio_i, status_raw[5:0]};
        end
        return mdl[(a == 3'h7) ? 3'h6 : a];
    endfunction : exp_rd
    // Pointer load with optional write, then read back
    task automatic acc(input logic [2:0] a, input bit w, input logic [7:0] v);
        hsc_pkg::hsc_bus_req_t r;
        r = '0;
        r.ptr_load = 1'b1;
        r.ptr_val = {5'($urandom), a};
        r.wr_en = w;
        r.wr_data = v;
        u_host.xfer(r);
        if (w && a == 3'h0) mdl[0] = v;
        if (w && a == 3'h1) mdl[1] = v & 8'h7F;
        if (w && a == 3'h3) mdl[3] = v & 8'h3F;
        if (w && a > 3'h3 && mdl[0][5]) mdl[(a == 3'h7) ? 3'h6 : a] = v;
        @(negedge sys_clk);
        check(rd_data, exp_rd(a));
    endtask : acc
    task automatic rel(input bit ara);
        hsc_pkg::hsc_bus_req_t r;
        r = '0;
        r.addressed = !ara;
        r.ara_won = ara;
        u_host.xfer(r);
    endtask : rel
    task automatic pulse(input int k);
        fault_evt = 6'(1 << k);
        @(negedge sys_clk);
        fault_evt = '0;
        mdl[3][k] = 1'b1;
        @(negedge sys_clk);
    endtask : pulse
    task automatic report_and_stop;
        $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(61));
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check(rd_data, 8'h13);
        check({mass_write_en, adc_halt, switch_on, oc_retry, uv_retry, ov_retry, alert_oe}, 8'h46);
        for (int i = 0; i < 8; i++) acc(3'(i), 1'b0, 8'h00);
        $display("test reset values done");
        on_pin = 1'b1;
        debounce_done = 1'b1;
        @(negedge sys_clk);
        debounce_done = 1'b0;
        mdl[0][3] = 1'b1;
        @(negedge sys_clk);
        check(switch_on, 1'b1);
        $display("test switch default done");
        status_raw = 8'($urandom);
        gpio_i = 1'($urandom);
        for (int i = 0; i < 40; i++) begin
            p = 3'($urandom);
            d = 8'($urandom);
            acc(p, 1'b1, (p == 3'h3) ? 8'h00 : d);
        end
        $display("test random access done");
        for (int t = 0; t < 2; t++) begin
            acc(3'h0, 1'b1, {2'b00, t[0], 5'h03});
            d = 8'($urandom);
            adc_res = '{1'b1, hsc_pkg::hsc_adc_ch_t'(t), d};
            @(negedge sys_clk);
            adc_res = '0;
            if (t == 0) mdl[4] = d;
            acc(3'(4 + t), 1'b0, 8'h00);
        end
        $display("test converter done");
        for (int f = 0; f < 4; f++) begin
            for (int g = 0; g < 2; g++) begin
                acc(3'h1, 1'b1, {1'b0, g[0], 6'h00});
                acc(3'h0, 1'b1, {f[1:0], 6'h13});
                check(gpio_oe, f != 3);
                if (f != 3) check(gpio_o, (f == 0) ? !status_raw[3] : (f == 2) ? status_raw[3] : g[0]);
            end
        end
        $display("test gpio done");
        acc(3'h3, 1'b1, 8'h00);
        rel(1'b0);
        for (int k = 0; k < 6; k++) begin
            en = 8'($urandom);
            acc(3'h1, 1'b1, en);
            pulse(k);
            check(alert_oe, en[k]);
            rel(k[0]);
            @(negedge sys_clk);
            check(alert_oe, 1'b0);
            pulse(k);
            check(alert_oe, 1'b0);
            acc(3'h3, 1'b0, 8'h00);
            acc(3'h3, 1'b1, 8'h00);
        end
        $display("test alert done");
        report_and_stop();
    end
endmodule : tb_hsc_regs
bind hsc_regs hsc_regs_properties u_props (.sys_clk(sys_clk), .rst(rst),
    .bus_req(bus_req), .fault_evt(fault_evt), .status_raw(status_raw),
    .gpio_i(gpio_i), .rd_data(rd_data), .mass_write_en(mass_write_en),
    .adc_halt(adc_halt), .switch_on(switch_on), .oc_retry(oc_retry),
    .gpio_oe(gpio_oe), .alert_n_o(alert_n_o), .alert_oe(alert_oe));
`default_nettype wire

/* File: rtl/hsc_pkg.sv */
`default_nettype none
package hsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register pointer decode
    localparam int unsigned PTR_DEC_W = 3;
    localparam logic [2:0] OFS_CONTROL        = 3'h0;
    localparam logic [2:0] OFS_ALERT_ENABLE   = 3'h1;
    localparam logic [2:0] OFS_STATUS         = 3'h2;
    localparam logic [2:0] OFS_FAULT_LOG      = 3'h3;
    localparam logic [2:0] OFS_CURRENT_SENSE  = 3'h4;
    localparam logic [2:0] OFS_OUTPUT_VOLTAGE = 3'h5;
    localparam logic [2:0] OFS_AUX_INPUT      = 3'h6;
    localparam logic [2:0] OFS_AUX_INPUT_ALT  = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int unsigned CTL_GPIO_HI   = 7;
    localparam int unsigned CTL_GPIO_LO   = 6;
    localparam int unsigned CTL_TEST      = 5;
    localparam int unsigned CTL_MASS_WR   = 4;
    localparam int unsigned CTL_SWITCH_ON = 3;
    localparam int unsigned CTL_OC_RETRY  = 2;
    localparam int unsigned CTL_UV_RETRY  = 1;
    localparam int unsigned CTL_OV_RETRY  = 0;
    localparam logic [7:0]  CTL_RST       = 8'h13;

    ////////////////////////////////////////////////////////////////////////
    // Alert register fields
    localparam int unsigned ALR_GPIO_OUT = 6;
    localparam logic [7:0]  ALR_MASK     = 8'h7F;
    localparam logic [7:0]  ALR_RST      = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Status and fault log fields
    localparam int unsigned STS_GPIO_IN   = 6;
    localparam int unsigned STS_PWR_BAD   = 3;
    localparam logic [7:0]  FLT_MASK      = 8'h3F;
    localparam logic [7:0]  FLT_RST       = 8'h00;
    localparam logic [7:0]  ADC_RST       = 8'h00;
    localparam logic [7:0]  PTR_RST       = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // GPIO pin function, field value {bit7, bit6}
    typedef enum logic [1:0] {
        HSC_GPIO_PWR_GOOD = 2'b00,
        HSC_GPIO_PWR_BAD  = 2'b10,
        HSC_GPIO_OUTPUT   = 2'b01,
        HSC_GPIO_INPUT    = 2'b11
    } hsc_gpio_fn_t;

    // ADC channel select
    typedef enum logic [1:0] {
        HSC_ADC_SENSE = 2'b00,
        HSC_ADC_VOUT  = 2'b01,
        HSC_ADC_AUX   = 2'b10
    } hsc_adc_ch_t;

    ////////////////////////////////////////////////////////////////////////
    // Request from the serial protocol engine
    typedef struct packed {
        logic       ptr_load;
        logic [7:0] ptr_val;
        logic       wr_en;
        logic [7:0] wr_data;
        logic       addressed;
        logic       ara_won;
    } hsc_bus_req_t;

    // Converter result
    typedef struct packed {
        logic        valid;
        hsc_adc_ch_t ch;
        logic [7:0]  data;
    } hsc_adc_res_t;

endpackage : hsc_pkg
`default_nettype wire

/* File: rtl/hsc_regs.sv */
// Overview of operation
// - Decode only low three pointer bits
// - ADC registers writable only in test mode
// - Control register at 00h, read/write
// - Alert enable register at 01h
// - Sense 04h, voltage 05h, status 02h, fault 03h
// - Pointers 06h and 07h alias aux data
// - GPIO field selects pin drive source
// - Test mode halts ADC, resets off
// - Mass write enable bit, resets enabled
// - Switch bit drives transistor, on-pin at debounce
// - Overcurrent autoretry or latch-off select
// - Undervoltage autoretry, default enabled
// - Overvoltage autoretry, default enabled
// - GPIO output data bit, resets zero
// - Transistor short alert enable, resets zero
// - Board presence change alert enable
// - Power bad alert enable, resets zero
// - Overcurrent, undervoltage, overvoltage alert enables
// - Release alert when individually addressed
// - No new alert until fault bit cleared
// - Pointer kept after transaction ends
`default_nettype none
module hsc_regs (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Protocol engine side
    input  wire hsc_pkg::hsc_bus_req_t bus_req,
    output logic [7:0]                 rd_data,
    output logic                       mass_write_en,
    // Converter side
    input  wire hsc_pkg::hsc_adc_res_t adc_res,
    output logic                       adc_halt,
    // Fault events and live conditions
    input  wire logic [5:0]            fault_evt,
    input  wire logic [7:0]            status_raw,
    // Switch control
    input  wire logic                  on_pin,
    input  wire logic                  debounce_done,
    output logic                       switch_on,
    output logic                       oc_retry,
    output logic                       uv_retry,
    output logic                       ov_retry,
    // GPIO pin
    input  wire logic                  gpio_i,
    output logic                       gpio_o,
    output logic                       gpio_oe,
    // Alert pin, open drain
    output logic                       alert_n_o,
    output logic                       alert_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] ptr_r;
    logic [7:0] control_r;
    logic [7:0] alert_enable_r;
    logic [7:0] fault_log_r;
    logic [7:0] fault_log_nxt;
    logic [7:0] current_sense_data_r;
    logic [7:0] output_voltage_data_r;
    logic [7:0] aux_input_data_r;
    logic [7:0] status_word;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic       on_capture_armed_r;
    logic       alert_r;
    logic       alert_nxt;
    logic [2:0] sel;
    logic [2:0] wr_sel;
    logic       test_mode;
    logic [5:0] new_fault;
    logic       gpio_o_r;
    logic       gpio_o_nxt;
    logic       gpio_oe_r;
    logic       gpio_oe_nxt;
    hsc_pkg::hsc_gpio_fn_t gpio_fn;

    ////////////////////////////////////////////////////////////////////////
    // Pointer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptr_r <= hsc_pkg::PTR_RST;
        end else if (bus_req.ptr_load) begin
            ptr_r <= bus_req.ptr_val;
        end
    end

    // Upper five pointer bits never take part in decode
    assign sel = ptr_r[hsc_pkg::PTR_DEC_W-1:0];
    assign wr_sel = bus_req.ptr_load ?
                    bus_req.ptr_val[hsc_pkg::PTR_DEC_W-1:0] : sel;
    assign test_mode = control_r[hsc_pkg::CTL_TEST];

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control_r <= hsc_pkg::CTL_RST;
            on_capture_armed_r <= 1'b1;
        end else if (bus_req.wr_en &&
                     wr_sel == hsc_pkg::OFS_CONTROL) begin
            control_r <= bus_req.wr_data;
            on_capture_armed_r <= 1'b0;
        end else if (debounce_done && on_capture_armed_r) begin
            control_r[hsc_pkg::CTL_SWITCH_ON] <= on_pin;
            on_capture_armed_r <= 1'b0;
        end
    end

    assign switch_on     = control_r[hsc_pkg::CTL_SWITCH_ON];
    assign oc_retry      = control_r[hsc_pkg::CTL_OC_RETRY];
    assign uv_retry      = control_r[hsc_pkg::CTL_UV_RETRY];
    assign ov_retry      = control_r[hsc_pkg::CTL_OV_RETRY];
    assign mass_write_en = control_r[hsc_pkg::CTL_MASS_WR];
    assign adc_halt      = test_mode;

    ////////////////////////////////////////////////////////////////////////
    // Alert enable register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alert_enable_r <= hsc_pkg::ALR_RST;
        end else if (bus_req.wr_en &&
                     wr_sel == hsc_pkg::OFS_ALERT_ENABLE) begin
            // Top bit is not stored
            alert_enable_r <= bus_req.wr_data & hsc_pkg::ALR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault log, a new event wins over a host write
    always_comb begin
        fault_log_nxt = fault_log_r;
        if (bus_req.wr_en && wr_sel == hsc_pkg::OFS_FAULT_LOG) begin
            fault_log_nxt = bus_req.wr_data;
        end
        fault_log_nxt = (fault_log_nxt | {2'b00, fault_evt}) &
                        hsc_pkg::FLT_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_log_r <= hsc_pkg::FLT_RST;
        end else begin
            fault_log_r <= fault_log_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter data registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            current_sense_data_r <= hsc_pkg::ADC_RST;
        end else if (test_mode) begin
            if (bus_req.wr_en && wr_sel == hsc_pkg::OFS_CURRENT_SENSE) begin
                current_sense_data_r <= bus_req.wr_data;
            end
        end else if (adc_res.valid && adc_res.ch == hsc_pkg::HSC_ADC_SENSE) begin
            current_sense_data_r <= adc_res.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            output_voltage_data_r <= hsc_pkg::ADC_RST;
        end else if (test_mode) begin
            if (bus_req.wr_en &&
                wr_sel == hsc_pkg::OFS_OUTPUT_VOLTAGE) begin
                output_voltage_data_r <= bus_req.wr_data;
            end
        end else if (adc_res.valid && adc_res.ch == hsc_pkg::HSC_ADC_VOUT) begin
            output_voltage_data_r <= adc_res.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aux_input_data_r <= hsc_pkg::ADC_RST;
        end else if (test_mode) begin
            if (bus_req.wr_en &&
                (wr_sel == hsc_pkg::OFS_AUX_INPUT ||
                 wr_sel == hsc_pkg::OFS_AUX_INPUT_ALT)) begin
                aux_input_data_r <= bus_req.wr_data;
            end
        end else if (adc_res.valid && adc_res.ch == hsc_pkg::HSC_ADC_AUX) begin
            aux_input_data_r <= adc_res.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word, live pin level in the GPIO bit
    always_comb begin
        status_word = status_raw;
        status_word[hsc_pkg::STS_GPIO_IN] = gpio_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data follows the pointer
    always_comb begin
        case (sel)
            hsc_pkg::OFS_CONTROL: begin
                rd_data_nxt = control_r;
            end
            hsc_pkg::OFS_ALERT_ENABLE: begin
                rd_data_nxt = alert_enable_r & hsc_pkg::ALR_MASK;
            end
            hsc_pkg::OFS_STATUS: begin
                rd_data_nxt = status_word;
            end
            hsc_pkg::OFS_FAULT_LOG: begin
                rd_data_nxt = fault_log_r;
            end
            hsc_pkg::OFS_CURRENT_SENSE: begin
                rd_data_nxt = current_sense_data_r;
            end
            hsc_pkg::OFS_OUTPUT_VOLTAGE: begin
                rd_data_nxt = output_voltage_data_r;
            end
            hsc_pkg::OFS_AUX_INPUT, hsc_pkg::OFS_AUX_INPUT_ALT: begin
                rd_data_nxt = aux_input_data_r;
            end
            default: begin
                rd_data_nxt = aux_input_data_r;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_r <= hsc_pkg::CTL_RST;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;

    ////////////////////////////////////////////////////////////////////////
    // GPIO pin drive
    assign gpio_fn = hsc_pkg::hsc_gpio_fn_t'(
                     {control_r[hsc_pkg::CTL_GPIO_HI],
                      control_r[hsc_pkg::CTL_GPIO_LO]});

    always_comb begin
        gpio_o_nxt  = 1'b0;
        gpio_oe_nxt = 1'b1;
        case (gpio_fn)
            hsc_pkg::HSC_GPIO_PWR_GOOD: begin
                gpio_o_nxt = ~status_raw[hsc_pkg::STS_PWR_BAD];
            end
            hsc_pkg::HSC_GPIO_PWR_BAD: begin
                gpio_o_nxt = status_raw[hsc_pkg::STS_PWR_BAD];
            end
            hsc_pkg::HSC_GPIO_OUTPUT: begin
                gpio_o_nxt = alert_enable_r[hsc_pkg::ALR_GPIO_OUT];
            end
            hsc_pkg::HSC_GPIO_INPUT: begin
                gpio_oe_nxt = 1'b0;
            end
            default: begin
                gpio_oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gpio_o_r  <= 1'b0;
            gpio_oe_r <= 1'b0;
        end else begin
            gpio_o_r  <= gpio_o_nxt;
            gpio_oe_r <= gpio_oe_nxt;
        end
    end

    assign gpio_o  = gpio_o_r;
    assign gpio_oe = gpio_oe_r;

    ////////////////////////////////////////////////////////////////////////
    // Alert, raised only by a fault bit going from clear to set
    assign new_fault = fault_log_nxt[5:0] & ~fault_log_r[5:0] &
                       alert_enable_r[5:0];

    always_comb begin
        alert_nxt = alert_r;
        if (bus_req.addressed || bus_req.ara_won) begin
            alert_nxt = 1'b0;
        end
        if (|new_fault) begin
            alert_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alert_r <= 1'b0;
        end else begin
            alert_r <= alert_nxt;
        end
    end

    // Pulled low while an alert is pending
    assign alert_n_o = 1'b0;
    assign alert_oe  = alert_r;

endmodule : hsc_regs
`default_nettype wire
